// ==== src/ddc_cfg_defs.svh ====
// register indices, field positions, reset values and sizes for the
// two-channel down-converter configuration block.
// assumes: included by the package, by stage_gain and by the top design module.
`ifndef DDC_CFG_DEFS_SVH
`define DDC_CFG_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_CH0_GAIN    10'h130
`define IDX_CH0_INC_LO  10'h131
`define IDX_CH0_INC_HI  10'h132
`define IDX_CH1_GAIN    10'h138
`define IDX_CH1_INC_LO  10'h139
`define IDX_CH1_INC_HI  10'h13a
`define IDX_STATUS      10'h140

// field positions inside the gain register
`define GAIN_D2_HI 5
`define GAIN_D2_LO 4
`define GAIN_D8_HI 1
`define GAIN_D8_LO 0
// bits 9:8 of the increment sit in bits 1:0 of the upper register
`define INC_HI_HI 1
`define INC_HI_LO 0

`define CFG_RESET 8'h00
`define INC_BITS 10
`define PHASE_MOD 1024
`define SAMPLE_BITS 12
`define LANE_BITS 16
`define FIFO_WIDTH 32
`define FIFO_DEPTH 16
`define DEC_LAST 3'h7

`endif

// ==== src/ddc_cfg_pkg.sv ====
// types shared by the down-converter configuration block.
// assumes: ddc_cfg_defs.svh is on the include path.
`include "ddc_cfg_defs.svh"

package ddc_cfg_pkg;

	typedef struct packed {
		logic [1:0][1:0] gain_d2;
		logic [1:0][1:0] gain_d8;
		logic [1:0][`INC_BITS-1:0] inc;
		logic [1:0][`INC_BITS-1:0] phase;
		logic [1:0][`LANE_BITS-1:0] half;
		logic [1:0][`LANE_BITS+1:0] acc8;
		logic [2:0] cnt;
		logic push;
		logic [`FIFO_WIDTH-1:0] word;
		logic ready;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cfg_state_t;

endpackage

// ==== src/stage_gain.sv ====
// saturating gain of a polyphase stage in 6 dB steps.
// assumes: purely combinational, select from registers, data partly from sample_i.
`timescale 1ns/10ps
`include "ddc_cfg_defs.svh"

module stage_gain (
	input wire logic [`LANE_BITS-1:0] data_i, // signed stage output
	input wire logic [1:0] sel_i,              // 00..11 = 0..18 dB
	output logic [`LANE_BITS-1:0] data_o       // gained, saturated
);

	logic signed [`LANE_BITS+2:0] wide;

	// one doubling per step; clipping beats wrap-around on a spectrum
	always_comb
	begin
		wide = 19'($signed(data_i)) <<< sel_i;
		if (wide > 19'sh0_7fff)
			data_o = 16'h7fff;
		else if (wide < -19'sh0_8000)
			data_o = 16'h8000;
		else
			data_o = wide[`LANE_BITS-1:0];
	end

endmodule

// ==== src/sample_fifo.sv ====
// word FIFO with a registered head, valid/ready on both sides.
// assumes: one clock, synchronous active-low reset.
`timescale 1ns/10ps

module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,               // clock
	input wire logic rst_n_i,             // sync reset, low
	input wire logic [WIDTH-1:0] in_data_i, // word to store
	input wire logic in_valid_i,          // word offered
	output logic in_ready_o,              // room in store
	output logic [WIDTH-1:0] out_data_o,  // head word
	output logic out_valid_o,             // head valid
	input wire logic out_ready_i          // head taken
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
		logic ovalid;
		logic [WIDTH-1:0] odata;
	} fifo_state_t;

	fifo_state_t st_q;
	fifo_state_t st_d;
	logic push;
	logic pop;

	assign in_ready_o = st_q.count != (AW+1)'(DEPTH);
	assign out_valid_o = st_q.ovalid;
	assign out_data_o = st_q.odata;

	// head register keeps the output free of the memory read mux
	always_comb
	begin
		st_d = st_q;
		push = in_valid_i && in_ready_o;
		pop = (st_q.count != '0) && (!st_q.ovalid || out_ready_i);
		if (out_ready_i)
			st_d.ovalid = 1'b0;
		if (pop)
		begin
			st_d.odata = st_q.mem[st_q.rd];
			st_d.ovalid = 1'b1;
			st_d.rd = st_q.rd + 1'b1;
		end
		if (push)
		begin
			st_d.mem[st_q.wr] = in_data_i;
			st_d.wr = st_q.wr + 1'b1;
		end
		st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

endmodule

// ==== src/downconverter_gain_nco_config.sv ====
// two down-converter channels: oscillator mixer, decimate-by-2 and
// decimate-by-8 stages with gain, APB register file, output FIFO.
// assumes: samples and APB are synchronous to clk_i; output side may
// stall, which stalls sample intake.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ddc_cfg_defs.svh"

module downconverter_gain_nco_config (
	input wire logic clk_i,                  // 100 MHz clock
	input wire logic rst_n_i,                // sync reset, low
	input wire logic psel_i,                 // APB select
	input wire logic penable_i,              // APB access phase
	input wire logic pwrite_i,               // APB write
	input wire logic [11:0] paddr_i,         // APB byte address
	input wire logic [31:0] pwdata_i,        // APB write data
	input wire logic [3:0] pstrb_i,          // APB byte strobes
	output logic pready_o,                   // APB ready
	output logic [31:0] prdata_o,            // APB read data
	output logic pslverr_o,                  // APB error
	input wire logic [`SAMPLE_BITS-1:0] sample_i, // signed sample
	input wire logic sample_valid_i,         // sample offered
	output logic sample_ready_o,             // sample taken
	output logic [`FIFO_WIDTH-1:0] out_data_o, // {ch1, ch0} result
	output logic out_valid_o,                // result valid
	input wire logic out_ready_i             // result taken
);

	ddc_cfg_pkg::cfg_state_t st_q;
	ddc_cfg_pkg::cfg_state_t st_d;

	logic accept;
	logic wr_en;
	logic [9:0] idx;
	logic [7:0] rd_byte;
	logic fifo_in_ready;

	logic signed [1:0][19:0] mix_full;
	logic [1:0][`LANE_BITS-1:0] mix;
	logic [1:0][`LANE_BITS:0] pair_sum;
	logic [1:0][`LANE_BITS-1:0] d2_raw;
	logic [1:0][`LANE_BITS-1:0] d2_gained;
	logic [1:0][`LANE_BITS+1:0] quad_sum;
	logic [1:0][`LANE_BITS-1:0] d8_raw;
	logic [1:0][`LANE_BITS-1:0] d8_gained;

	// coarse cosine, eight points per turn, scaled by 127
	function automatic logic signed [7:0] cos_lut(input logic [2:0] ph);
		unique case (ph)
			3'h0: cos_lut = 8'sh7f;
			3'h1: cos_lut = 8'sh5a;
			3'h2: cos_lut = 8'sh00;
			3'h3: cos_lut = -8'sh5a;
			3'h4: cos_lut = -8'sh7f;
			3'h5: cos_lut = -8'sh5a;
			3'h6: cos_lut = 8'sh00;
			3'h7: cos_lut = 8'sh5a;
		endcase
	endfunction

	// word-aligned addresses of the mapped registers only
	function automatic logic addr_hit(input logic [11:0] a);
		logic [9:0] i;
		i = a[11:2];
		addr_hit = (a[1:0] == 2'b00) &&
			(i == `IDX_CH0_GAIN || i == `IDX_CH0_INC_LO ||
			i == `IDX_CH0_INC_HI || i == `IDX_CH1_GAIN ||
			i == `IDX_CH1_INC_LO || i == `IDX_CH1_INC_HI ||
			i == `IDX_STATUS);
	endfunction

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_chan
			// mix with the oscillator; phase top bits address the table
			assign mix_full[c] = $signed(sample_i) *
				cos_lut(st_q.phase[c][`INC_BITS-1 -: 3]);
			assign mix[c] = {{3{mix_full[c][19]}}, mix_full[c][19:7]};

			// decimate by 2: mean of a sample pair
			assign pair_sum[c] = {st_q.half[c][`LANE_BITS-1], st_q.half[c]} +
				{mix[c][`LANE_BITS-1], mix[c]};
			assign d2_raw[c] = pair_sum[c][`LANE_BITS:1];

			stage_gain u_gain_d2 (
				.data_i(d2_raw[c]),
				.sel_i(st_q.gain_d2[c]),
				.data_o(d2_gained[c])
			);

			// decimate by 4 more: mean of four stage outputs, 8 overall
			assign quad_sum[c] = st_q.acc8[c] +
				{{2{d2_gained[c][`LANE_BITS-1]}}, d2_gained[c]};
			assign d8_raw[c] = quad_sum[c][`LANE_BITS+1:2];

			stage_gain u_gain_d8 (
				.data_i(d8_raw[c]),
				.sel_i(st_q.gain_d8[c]),
				.data_o(d8_gained[c])
			);
		end
	endgenerate

	assign idx = paddr_i[11:2];
	assign accept = sample_valid_i && st_q.ready;
	assign wr_en = psel_i && penable_i && st_q.pready && pwrite_i &&
		!st_q.pslverr && pstrb_i[0];

	// read view; unused bits are forced low
	always_comb
	begin
		unique case (idx)
			`IDX_CH0_GAIN:
				rd_byte = {2'b00, st_q.gain_d2[0], 2'b00, st_q.gain_d8[0]};
			`IDX_CH0_INC_LO:
				rd_byte = st_q.inc[0][7:0];
			`IDX_CH0_INC_HI:
				rd_byte = {6'h00, st_q.inc[0][9:8]};
			`IDX_CH1_GAIN:
				rd_byte = {2'b00, st_q.gain_d2[1], 2'b00, st_q.gain_d8[1]};
			`IDX_CH1_INC_LO:
				rd_byte = st_q.inc[1][7:0];
			`IDX_CH1_INC_HI:
				rd_byte = {6'h00, st_q.inc[1][9:8]};
			`IDX_STATUS:
				rd_byte = {3'h0, st_q.ready, st_q.push, st_q.cnt};
			default:
				rd_byte = 8'h00;
		endcase
	end

	always_comb
	begin
		st_d = st_q;

		// APB: setup cycle loads the answer, access cycle completes
		st_d.pready = 1'b0;
		if (psel_i && !penable_i)
		begin
			st_d.pready = 1'b1;
			st_d.pslverr = !addr_hit(paddr_i);
			st_d.prdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
		end

		if (wr_en)
		begin
			unique case (idx)
				`IDX_CH0_GAIN:
				begin
					st_d.gain_d2[0] = pwdata_i[`GAIN_D2_HI:`GAIN_D2_LO];
					st_d.gain_d8[0] = pwdata_i[`GAIN_D8_HI:`GAIN_D8_LO];
				end
				`IDX_CH0_INC_LO:
					st_d.inc[0][7:0] = pwdata_i[7:0];
				`IDX_CH0_INC_HI:
					st_d.inc[0][9:8] = pwdata_i[`INC_HI_HI:`INC_HI_LO];
				`IDX_CH1_GAIN:
				begin
					st_d.gain_d2[1] = pwdata_i[`GAIN_D2_HI:`GAIN_D2_LO];
					st_d.gain_d8[1] = pwdata_i[`GAIN_D8_HI:`GAIN_D8_LO];
				end
				`IDX_CH1_INC_LO:
					st_d.inc[1][7:0] = pwdata_i[7:0];
				`IDX_CH1_INC_HI:
					st_d.inc[1][9:8] = pwdata_i[`INC_HI_HI:`INC_HI_LO];
				default:
					st_d.prdata = st_q.prdata;
			endcase
		end

		// a finished word leaves as soon as the FIFO has room
		if (st_q.push && fifo_in_ready)
			st_d.push = 1'b0;

		if (accept)
		begin
			st_d.cnt = st_q.cnt + 3'h1;
			for (int k = 0; k < 2; k++)
			begin
				// 10-bit wrap gives f = inc * fs / 1024
				st_d.phase[k] = st_q.phase[k] + st_q.inc[k];
				if (!st_q.cnt[0])
					st_d.half[k] = mix[k];
				else if (st_q.cnt != `DEC_LAST)
					st_d.acc8[k] = quad_sum[k];
				else
				begin
					st_d.acc8[k] = '0;
					st_d.word[k*`LANE_BITS +: `LANE_BITS] = d8_gained[k];
				end
			end
			if (st_q.cnt == `DEC_LAST)
				st_d.push = 1'b1;
		end

		// intake pauses while a word waits, so no result is ever dropped
		st_d.ready = !st_d.push;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	sample_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_data_i(st_q.word),
		.in_valid_i(st_q.push),
		.in_ready_o(fifo_in_ready),
		.out_data_o(out_data_o),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i)
	);

	assign pready_o = st_q.pready;
	assign prdata_o = st_q.prdata;
	assign pslverr_o = st_q.pslverr;
	assign sample_ready_o = st_q.ready;

endmodule

// ==== testbench/sample_partner.sv ====
// far side model: converter sample source and output framer sink.
// assumes: bench starts groups of eight samples; sync low reset.
`timescale 1ns/10ps
module sample_partner (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic [11:0] value_i, // sample
	input wire logic start_i, // send eight
	input wire logic stall_i, // sink stalls
	input wire logic take_i, // accepted
	output logic [11:0] sample_o = 12'h000, // to block
	output logic valid_o = 1'b0, // offered
	output logic ready_o = 1'b0, // sink ready
	output logic busy_o // group open
);
	logic [3:0] left_q = 4'h0;
	assign busy_o = left_q != 4'h0;
	always @(posedge clk_i)
	begin
		ready_o <= !stall_i;
		if (!rst_n_i || (valid_o && take_i && left_q == 4'h1))
		begin
			left_q <= 4'h0;
			valid_o <= 1'b0;
			// released line shows the inverse so a stale sample cannot pass
			sample_o <= ~sample_o;
		end
		else if (start_i)
		begin
			left_q <= 4'h8;
			valid_o <= 1'b1;
			sample_o <= value_i;
		end
		else if (valid_o && take_i)
			left_q <= left_q - 4'h1;
	end
endmodule

// ==== testbench/ddc_cfg_checker.sv ====
// port assertions for the configuration block.
// assumes: bound to the top module; one clock, sync low reset.
`timescale 1ns/10ps
module ddc_cfg_checker (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // reset
	input wire logic psel_i, // select
	input wire logic penable_i, // enable
	input wire logic pwrite_i, // write
	input wire logic [11:0] paddr_i, // addr
	input wire logic [31:0] pwdata_i, // wdata
	input wire logic [3:0] pstrb_i, // strobe
	input wire logic pready_o, // ready
	input wire logic [31:0] prdata_o, // rdata
	input wire logic pslverr_o, // error
	input wire logic [31:0] out_data_o, // result
	input wire logic out_valid_o, // valid
	input wire logic out_ready_i // taken
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire rd = psel_i && penable_i && pready_o && !pwrite_i && !pslverr_o;
	sequence s_wr;
		psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == 12'h4c0;
	endsequence
	sequence s_rd;
		psel_i && !penable_i && !pwrite_i && paddr_i == 12'h4c0;
	endsequence
	property p_answer; psel_i && !penable_i |=> pready_o; endproperty
	a_answer: assert property (p_answer) else $error("no ready after setup");
	property p_pulse; pready_o |=> !pready_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_upper; rd |-> prdata_o[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_gain; rd && (paddr_i == 12'h4c0 || paddr_i == 12'h4e0)
		|-> prdata_o[7:6] == 2'b00 && prdata_o[3:2] == 2'b00; endproperty
	a_gain: assert property (p_gain) else $error("gain unused bits set");
	property p_inc; rd && (paddr_i == 12'h4c8 || paddr_i == 12'h4e8)
		|-> prdata_o[7:2] == 6'h00; endproperty
	a_inc: assert property (p_inc) else $error("increment unused bits set");
	property p_reset;
		$rose(rst_n_i) |-> !pready_o && !out_valid_o && out_data_o == 32'h0000_0000;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs busy after reset");
	property p_back;
		s_wr ##1 s_rd |=> prdata_o == ($past(pwdata_i, 2) & 32'h0000_0033);
	endproperty
	a_back: assert property (p_back) else $error("gain readback wrong");
	property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o); endproperty
	a_hold: assert property (p_hold) else $error("result dropped while stalled");
endmodule
bind downconverter_gain_nco_config ddc_cfg_checker i_chk (.clk_i, .rst_n_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .out_data_o,
	.out_valid_o, .out_ready_i);

// ==== testbench/tb.sv ====
// bench: registers over APB, then sample groups through both channels.
// assumes: the partner model sources samples and sinks results.
`timescale 1ns/10ps
`include "ddc_cfg_defs.svh"
module tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic start = 1'b0, hold = 1'b1, stall = 1'b1, busy, pready_o, pslverr_o;
	logic sample_valid_i, sample_ready_o, out_valid_o, out_ready_i;
	logic [11:0] paddr_i = 12'h000, sample_i, value = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, out_data_o, out_q[$];
	logic [3:0] pstrb_i = 4'h0;
	logic [3:0] strb = 4'h1;
	logic [33:0] be, bus_q[$];
	logic [9:0] idx[6] = '{`IDX_CH0_GAIN, `IDX_CH0_INC_LO, `IDX_CH0_INC_HI, `IDX_CH1_GAIN,
		`IDX_CH1_INC_LO, `IDX_CH1_INC_HI};
	logic [7:0] msk[6] = '{8'h33, 8'hff, 8'h03, 8'h33, 8'hff, 8'h03};
	int n_errors = 0, tests_run = 0, seed = 32'h605c_7cb9, n;
	downconverter_gain_nco_config i_dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .sample_i,
		.sample_valid_i, .sample_ready_o, .out_data_o, .out_valid_o, .out_ready_i);
	sample_partner i_far (.clk_i, .rst_n_i, .value_i(value), .start_i(start), .stall_i(stall),
		.take_i(sample_ready_o), .sample_o(sample_i), .valid_o(sample_valid_i),
		.ready_o(out_ready_i), .busy_o(busy));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) stall <= hold || $random(seed) % 2 != 0;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// each stage saturates on its own, so the first shift may clip already
	function automatic logic signed [15:0] sh(input logic signed [17:0] v, input logic [1:0] g);
		logic signed [21:0] w;
		w = v <<< g;
		if (w > 22'sh7fff)
			return 16'h7fff;
		if (w < -22'sh8000)
			return 16'h8000;
		return w[15:0];
	endfunction
	task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d,
		input logic [32:0] e);
		bus_q.push_back({!wr, e});
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {a, 2'b00};
		pwdata_i <= {24'h00_0000, d};
		pstrb_i <= strb;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no count of its own: only the watchdog ends an answer that never comes
		do
			@(posedge clk_i);
		while (!pready_o);
	endtask
	task automatic idle;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// constant multiples of 128 keep the mixer and averaging exact
	task automatic group(input int k, input logic [3:0] g, input logic [3:0] h, input logic z);
		logic signed [17:0] m;
		m = 18'(k * 127);
		apb(1'b1, `IDX_CH0_GAIN, {2'b00, g[3:2], 2'b00, g[1:0]}, 33'h0);
		apb(1'b1, `IDX_CH1_GAIN, {2'b00, h[3:2], 2'b00, h[1:0]}, 33'h0);
		idle;
		out_q.push_back({z ? 16'h0000 : sh(sh(m, h[3:2]), h[1:0]), sh(sh(m, g[3:2]), g[1:0])});
		value <= 12'(k * 128);
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		do
			@(posedge clk_i);
		while (busy);
	endtask
	task automatic drain;
		n = 0;
		while (out_q.size() > 0 && ++n < 3000)
			@(posedge clk_i);
	endtask
	always @(posedge clk_i)
		if (psel_i && penable_i && pready_o && bus_q.size() > 0)
		begin
			be = bus_q.pop_front();
			check({31'h0, pslverr_o}, {31'h0, be[32]});
			if (be[33])
				check(prdata_o, be[31:0]);
		end
	always @(posedge clk_i)
		if (out_valid_o && out_ready_i && out_q.size() > 0)
			check(out_data_o, out_q.pop_front());
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_errors++;
		final_report;
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, idx[i], 8'h00, 33'h0);
			apb(1'b1, idx[i], 8'hff, 33'h0);
			apb(1'b0, idx[i], 8'h00, {25'h0, msk[i]});
			apb(1'b1, idx[i], 8'h00, 33'h0);
		end
		apb(1'b0, 10'h13b, 8'h00, {1'b1, 32'h0});
		idle;
		$display("register test done");
		// sink held off: head plus sixteen stored words, the eighteenth must wait
		for (int i = 0; i < 18; i++)
			group($random(seed) % 16, (i < 16) ? 4'(i) : 4'($random(seed)), 4'(~i), 1'b0);
		repeat (4) @(posedge clk_i);
		check({31'h0, sample_ready_o}, 32'h0);
		hold <= 1'b0;
		drain;
		$display("fill and drain done");
		apb(1'b1, `IDX_CH1_INC_HI, 8'h02, 33'h0);
		group(-7, 4'h5, 4'h6, 1'b1);
		group(15, 4'hf, 4'h0, 1'b1);
		drain;
		check(32'(out_q.size()), 32'h0);
		$display("oscillator test done");
		// reset after the runs with settings loaded must clear the six settings registers; status reads ready
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		apb(1'b0, `IDX_STATUS, 8'h00, {25'h0, 8'h10});
		for (int i = 0; i < 6; i++)
			apb(1'b0, idx[i], 8'h00, 33'h0);
		// a write without its low byte strobe must leave the register alone
		strb = 4'he;
		apb(1'b1, `IDX_CH0_INC_LO, 8'h5a, 33'h0);
		strb = 4'h1;
		apb(1'b0, `IDX_CH0_INC_LO, 8'h00, 33'h0);
		idle;
		$display("reset test done");
		final_report;
	end
endmodule
